/* File: itx_top.sv */
/*
  two-wire slave transmitter with status reporting and bus-error recovery.
  assumes: scl/sda pins resolved open-drain by the surroundings; registers
  reached over axi4-lite on aclk.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module itx_top
  import itx_pkg::*;
#(
  parameter int HALF = HALF_CYCLES
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // two-wire pins, oe low means driving low
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  // arbitration-loss hint from the master side
  input  wire logic        arb_lost
);

  // refuse a half-bit count that the 16-bit start counter cannot hold
  if (HALF < 1 || HALF > 16'hffff)
  begin : g_half_bad
    $error("itx_top: HALF out of range");
  end

  itx_line_t  ev;
  itx_state_t state_q;
  logic       wr_pulse, wr_lane0, rd_hit, wr_hit;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  logic       done_q, ack_q, start_q, stop_q, en_q;
  logic [7:0] own_q, data_q, status_q, shift_q;
  logic [3:0] bit_q;
  logic       last_q, arb_q, gen_q;
  logic       sda_low_q, scl_low_q, busy_q;
  logic [15:0] gen_cnt_q;
  logic       ctrl_wr, done_clr, set_flag;
  logic [7:0] set_code;

  itx_lines u_lines
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .ev      (ev)
  );

  itx_axil u_axil
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .wr_pulse (wr_pulse),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .wr_lane0 (wr_lane0),
    .rd_pulse (),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .rd_hit   (rd_hit),
    .wr_hit   (wr_hit)
  );

  // register decode
  assign ctrl_wr  = wr_pulse && wr_lane0 && (wr_addr == ADDR_CTRL);
  assign done_clr = ctrl_wr && wr_data[CTL_DONE];
  assign wr_hit   = (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_DATA) ||
                    (wr_addr == ADDR_OWN) || (wr_addr == ADDR_STATUS);
  assign rd_hit   = (rd_addr == ADDR_CTRL) || (rd_addr == ADDR_DATA) ||
                    (rd_addr == ADDR_OWN) || (rd_addr == ADDR_STATUS);

  // read mux; status reads 0xf8 whenever the flag is clear
  always_comb
  begin
    rd_data = 8'h00;
    case (rd_addr)
      ADDR_CTRL:   rd_data = {done_q, ack_q, start_q, stop_q, 1'b0, en_q, 2'b00};
      ADDR_STATUS: rd_data = done_q ? status_q : ST_NONE;
      ADDR_DATA:   rd_data = data_q;
      ADDR_OWN:    rd_data = own_q;
      default:     rd_data = 8'h00;
    endcase
  end

  // own address and data registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      own_q  <= OWN_RST;
      data_q <= DATA_RST;
    end
    else if (wr_pulse && wr_lane0)
    begin
      if (wr_addr == ADDR_OWN)
        own_q <= wr_data;
      if (wr_addr == ADDR_DATA)
        data_q <= wr_data;
    end
  end

  // job done flag: hardware set wins over software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_q   <= 1'b0;
      status_q <= ST_NONE;
    end
    else if (set_flag)
    begin
      done_q   <= 1'b1;
      status_q <= set_code;
    end
    else if (done_clr)
    begin
      done_q <= 1'b0;
    end
  end

  // control bits; stop bit self-clears on error recovery
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_q   <= CTRL_RST[CTL_ACK];
      start_q <= CTRL_RST[CTL_START];
      stop_q  <= CTRL_RST[CTL_STOP];
      en_q    <= CTRL_RST[CTL_EN];
    end
    else if (ctrl_wr)
    begin
      ack_q   <= wr_data[CTL_ACK];
      start_q <= wr_data[CTL_START];
      en_q    <= wr_data[CTL_EN];
      // recovery from 0x00 forces stop to zero; ack, start and enable still load from the written data
      stop_q  <= (done_q && status_q == ST_BUSERR && wr_data[CTL_DONE]) ? 1'b0
                 : wr_data[CTL_STOP];
    end
    else if (gen_q && gen_cnt_q == 16'(HALF))
    begin
      start_q <= 1'b0;
    end
  end

  // bus busy tracking for start generation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      busy_q <= 1'b0;
    else if (ev.start)
      busy_q <= 1'b1;
    else if (ev.stop)
      busy_q <= 1'b0;
  end

  // start generation: pull sda low for a half bit once the bus is free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gen_q     <= 1'b0;
      gen_cnt_q <= 16'h0000;
    end
    else if (!gen_q)
    begin
      gen_cnt_q <= 16'h0000;
      // not-addressed slave, listening or ignoring, may start once the bus is free
      if (start_q && !done_q && !busy_q && (state_q == S_IDLE || state_q == S_IGN) &&
          ev.scl && ev.sda)
        gen_q <= 1'b1;
    end
    else if (gen_cnt_q == 16'(HALF))
    begin
      gen_q <= 1'b0;
    end
    else
    begin
      gen_cnt_q <= gen_cnt_q + 16'h0001;
    end
  end

  // engine events that set the flag
  always_comb
  begin
    set_flag = 1'b0;
    set_code = ST_NONE;
    if (en_q && (ev.start || ev.stop) && state_q != S_IDLE && state_q != S_WAIT &&
        state_q != S_IGN && !(state_q == S_ADDR && bit_q == 4'h0))
    begin
      set_flag = 1'b1;
      set_code = ST_BUSERR;
    end
    else if (state_q == S_AACK && ev.scl_fall)
    begin
      set_flag = 1'b1;
      set_code = arb_q ? ST_ARB_R : ST_OWN_ADDRESS_WITH_READ;
    end
    else if (state_q == S_RACK && ev.scl_rise)
    begin
      set_flag = 1'b1;
      if (ev.sda)
        set_code = ST_DAT_NAK;
      else if (last_q)
        set_code = ST_LAST_AK;
      else
        set_code = ST_DAT_ACK;
    end
  end

  // slave transmitter engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q   <= S_IDLE;
      shift_q   <= 8'h00;
      bit_q     <= 4'h0;
      last_q    <= 1'b0;
      arb_q     <= 1'b0;
    end
    else if (!en_q)
    begin
      state_q <= S_IDLE;
    end
    else if (set_flag && set_code == ST_BUSERR)
    begin
      state_q <= S_WAIT;
    end
    else
    begin
      case (state_q)
        S_IDLE, S_IGN:
        begin
          if (ev.start)
          begin
            state_q <= S_ADDR;
            bit_q   <= 4'h0;
            arb_q   <= arb_lost;
          end
        end
        S_ADDR:
        begin
          if (ev.start)
            bit_q <= 4'h0;
          else if (ev.scl_rise)
          begin
            shift_q <= {shift_q[6:0], ev.sda};
            bit_q   <= bit_q + 4'h1;
          end
          else if (ev.scl_fall && bit_q == 4'h8)
          begin
            // read address only; ack enable gates recognition
            if (addr_match(shift_q, own_q, ack_q))
              state_q <= S_AACK;
            else
              state_q <= S_IGN;
          end
        end
        S_AACK:
        begin
          if (ev.scl_fall)
            state_q <= S_WAIT;
        end
        S_WAIT:
        begin
          // flag clear releases the stretch; 0xf8 seen meanwhile
          if (done_clr && !set_flag)
          begin
            if (status_q == ST_BUSERR)
              state_q <= S_IDLE;
            else if (status_q == ST_DAT_NAK || status_q == ST_LAST_AK)
              state_q <= wr_data[CTL_ACK] ? S_IDLE : S_IGN;
            else
            begin
              state_q <= S_TX;
              shift_q <= data_q;
              bit_q   <= 4'h0;
              last_q  <= !wr_data[CTL_ACK];
            end
          end
        end
        S_TX:
        begin
          if (ev.scl_fall)
          begin
            if (bit_q == 4'h7)
              state_q <= S_RACK;
            else
            begin
              shift_q <= {shift_q[6:0], 1'b1};
              bit_q   <= bit_q + 4'h1;
            end
          end
        end
        S_RACK:
        begin
          if (ev.scl_rise)
            state_q <= S_WAIT;
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // line drivers, registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
    end
    else
    begin
      scl_low_q <= done_q && state_q == S_WAIT && status_q != ST_BUSERR;
      case (state_q)
        S_AACK:  sda_low_q <= 1'b1;
        S_TX:    sda_low_q <= !shift_q[7];
        default: sda_low_q <= gen_q;
      endcase
      if (set_flag && set_code == ST_BUSERR)
      begin
        sda_low_q <= 1'b0;
        scl_low_q <= 1'b0;
      end
    end
  end

  // open drain: output level always low, enable low while driving
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_n <= !scl_low_q;
      sda_oe_n <= !sda_low_q;
    end
  end

endmodule

/* File: itx_pkg.sv */
/*
  package for the two-wire slave transmitter block: register map, field layout,
  status codes, states and timing constants.
  assumes: included by every design file through itx_pkg::*.
*/
package itx_pkg;

  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] ADDR_CTRL   = 8'h00; // bus_control_register
  localparam logic [7:0] ADDR_STATUS = 8'h04; // bus_status_register
  localparam logic [7:0] ADDR_DATA   = 8'h08; // shift_data_register
  localparam logic [7:0] ADDR_OWN    = 8'h0c; // own_address_register

  // control field positions
  localparam int CTL_DONE  = 7; // job_done_flag, write one to clear
  localparam int CTL_ACK   = 6; // acknowledge_enable
  localparam int CTL_START = 5; // start_request
  localparam int CTL_STOP  = 4; // stop_request_bit
  localparam int CTL_EN    = 2; // interface enable

  // own address field positions
  localparam int OWN_GCE = 0; // general_call_enable
  localparam int OWN_MSB = 7;
  localparam int OWN_LSB = 1;

  // status codes, prescaler bits read as zero
  localparam logic [7:0] ST_OWN_ADDRESS_WITH_READ   = 8'ha8;
  localparam logic [7:0] ST_ARB_R   = 8'hb0;
  localparam logic [7:0] ST_DAT_ACK = 8'hb8;
  localparam logic [7:0] ST_DAT_NAK = 8'hc0;
  localparam logic [7:0] ST_LAST_AK = 8'hc8;
  localparam logic [7:0] ST_NONE    = 8'hf8;
  localparam logic [7:0] ST_BUSERR  = 8'h00;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hff;

  // start generation timing: half bit of standard mode
  localparam int CLK_MHZ     = 125;
  localparam int T_HALF_NS   = 5000;
  localparam int HALF_CYCLES = (T_HALF_NS * CLK_MHZ + 999) / 1000;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // bus engine states, one-hot
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, // not addressed, watching
    S_ADDR = 7'h02, // shifting in address byte
    S_AACK = 7'h04, // driving address acknowledge
    S_WAIT = 7'h08, // flag set, clock stretched unless bus error
    S_TX   = 7'h10, // shifting out data byte
    S_RACK = 7'h20, // sampling master acknowledge
    S_IGN  = 7'h40  // ignoring until the next start
  } itx_state_t;

  // line events from the edge detector
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic scl;
  } itx_line_t;

  // software actions presented to the engine
  typedef struct packed {
    logic clear;  // job_done_flag written with one
    logic ack_en;
    logic start;
    logic stop;
    logic enable;
  } itx_cmd_t;

  // address-match helper used for own-address recognition
  function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] own,
                                      input logic ack_en);
    addr_match = ack_en && rx[0] && (rx[7:1] == own[OWN_MSB:OWN_LSB]);
  endfunction

endpackage

/* File: itx_lines.sv */
/*
  line sampler: synchronises scl and sda and reports edges and conditions.
  assumes: scl_i and sda_i are pin levels from outside the aclk domain.
*/
`timescale 1ns/10ps
module itx_lines
  import itx_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  // decoded events
  output itx_line_t ev
);

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_q;
  logic       sda_q;

  // two-stage synchronisers; first stage read only by second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  // edges of the synchronised levels
  always_comb
  begin
    ev.scl      = scl_sync_q[1];
    ev.sda      = sda_sync_q[1];
    ev.scl_rise = scl_sync_q[1] && !scl_q;
    ev.scl_fall = !scl_sync_q[1] && scl_q;
    ev.start    = scl_sync_q[1] && scl_q && sda_q && !sda_sync_q[1];
    ev.stop     = scl_sync_q[1] && scl_q && !sda_q && sda_sync_q[1];
  end

endmodule

/* File: itx_axil.sv */
/*
  axi4-lite slave front end: accepts one write and one read at a time.
  assumes: single aclk domain; master keeps valid and payload until taken.
*/
`timescale 1ns/10ps
module itx_axil
  import itx_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register side
  output logic             wr_pulse,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic             wr_lane0,
  output logic             rd_pulse,
  output logic [7:0]       rd_addr,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit
);

  logic       aw_have_q;
  logic       w_have_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic       lane0_q;

  // write address and data captured in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      lane0_q   <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= wdata[7:0];
        lane0_q  <= wstrb[0];
      end
      if (wr_pulse)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  assign awready  = !aw_have_q && !bvalid && aresetn;
  assign wready   = !w_have_q && !bvalid && aresetn;
  assign wr_pulse = aw_have_q && w_have_q && !bvalid;
  assign wr_addr  = awaddr_q;
  assign wr_data  = wdata_q;
  assign wr_lane0 = lane0_q;

  // write response one cycle after both halves are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (wr_pulse)
    begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  assign arready  = !rvalid && aresetn;
  assign rd_pulse = arvalid && arready;
  assign rd_addr  = araddr;

  // read data registered one cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end
    else if (rd_pulse)
    begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_data};
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
    begin
      rvalid <= 1'b0;
    end
  end

endmodule

/* File: itx_assertions.sv */
/* checker for itx_top: bus handshakes, status codes and line holding.
   assumes: bound to itx_top, one aclk domain, synchronous active-low reset. */
`timescale 1ns/10ps
module itx_checker
  import itx_pkg::*;
#(
  parameter int HALF = HALF_CYCLES
)
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // pins
  input wire logic        scl_i,
  input wire logic        scl_oe_n,
  input wire logic        sda_oe_n
);
  int age_q;
  int low_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since write data was taken
  always_ff @(posedge aclk)
    if (!aresetn) age_q <= 99;
    else if (wvalid && wready) age_q <= 0;
    else if (age_q < 99) age_q <= age_q + 1;

  // cycles the data line has been pulled low
  always_ff @(posedge aclk)
    if (!aresetn || sda_oe_n) low_q <= 0;
    else low_q <= low_q + 1;

  sequence st_rd;
    arvalid && arready && araddr == ADDR_STATUS;
  endsequence
  sequence wr_both;
    awvalid && awready && wvalid && wready;
  endsequence

  bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  write_answer_a: assert property (wr_both |-> ##[1:2] bvalid)
    else $error("write answer late");
  ar_refuse_a: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  idle_status_a: assert property (
    st_rd ##1 rvalid |-> (rdata[7:0] == ST_NONE || rdata[7:0] == ST_BUSERR || !scl_oe_n)
    or ##[1:4] !scl_oe_n)
    else $error("status not idle code");
  stretch_release_a: assert property ($rose(scl_oe_n) |-> age_q < 6)
    else $error("clock released without write");
  start_hold_a: assert property ($rose(sda_oe_n) && scl_i |-> low_q >= HALF)
    else $error("start pull too short");
endmodule

bind itx_top itx_checker #(.HALF(HALF)) u_itx_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rvalid, .rready, .scl_i, .scl_oe_n,
  .sda_oe_n);

/* File: itx_master_rx.sv */
/* two-wire master receiver model facing the slave transmitter.
   assumes: the bench resolves both lines open-drain with pull-ups. */
`timescale 1ns/10ps
module itx_master_rx
(
  // resolved lines
  input  wire logic scl,
  input  wire logic sda,
  // pulls, low pulls the line down
  output logic      scl_oe_n,
  output logic      sda_oe_n
);
  // lines released while no frame runs
  initial
  begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end

  // one bit of 80 ns; a 50 ns low half leaves the slave time to settle its
  // data before the rise; waits out a stretched clock before the high half
  task automatic bitx(input logic b, output logic s);
    sda_oe_n = b;
    #40;
    scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #30;
    s = sda;
    scl_oe_n = 1'b0;
    #10;
  endtask

  task automatic start();
    sda_oe_n = 1'b0;
    #40;
    scl_oe_n = 1'b0;
    #10;
  endtask

  task automatic stop();
    sda_oe_n = 1'b0;
    #30;
    scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #40;
    sda_oe_n = 1'b1;
    #40;
  endtask

  // msb first, then the slave's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, ack);
  endtask

  // read eight bits, then answer ack (0) or not ack (1)
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nak, s);
  endtask
endmodule

/* File: i2c_slave_transmit_states_tb_top.sv */
/* bench for itx_top: register tasks, master receiver partner, status walk.
   assumes: itx_pkg, itx_top, checker and master model compiled first. */
`timescale 1ns/10ps
module i2c_slave_transmit_states_tb_top
  import itx_pkg::*;
;
  localparam logic [6:0] OWN_A = 7'h2a;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, arb_lost;
  logic        awready, wready, bvalid, arready, rvalid, scl_o, sda_o;
  logic        scl_oe_n, sda_oe_n, scl_i, sda_i, m_scl, m_sda;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp_q;
  int          mismatches, samples_checked;

  always #4 aclk = ~aclk;

  // open-drain lines with pull-ups
  assign scl_i = scl_oe_n & m_scl;
  assign sda_i = sda_oe_n & m_sda;

  itx_top #(.HALF(4)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .scl_i, .scl_o, .scl_oe_n, .sda_i, .sda_o, .sda_oe_n, .arb_lost);
  itx_master_rx M (.scl(scl_i), .sda(sda_i), .scl_oe_n(m_scl), .sda_oe_n(m_sda));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // write: address and data offered together, response taken when seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp_q = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    resp_q = rresp;
  endtask

  // poll status until the flag shows, then compare
  task automatic st(input logic [7:0] e);
    logic [31:0] v;
    int          n;
    n = 0;
    do
    begin
      rd(ADDR_STATUS, v);
      n++;
    end
    while (v[7:0] === ST_NONE && n < 40);
    chk(v, 32'(e), "status");
  endtask

  task automatic send(input logic [7:0] d, input logic [7:0] c);
    wr(ADDR_DATA, d);
    wr(ADDR_CTRL, c);
  endtask

  task automatic summarize();
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    #400000;
    mismatches++;
    summarize();
  end

  initial
  begin
    logic [31:0] v;
    logic [7:0]  d;
    logic        a;
    int          n;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, arb_lost} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    mismatches = 0;
    samples_checked = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and an unmapped place
    rd(ADDR_CTRL, v);
    chk(v, 32'(CTRL_RST), "ctrl reset");
    rd(ADDR_OWN, v);
    chk(v, 32'(OWN_RST), "own reset");
    rd(ADDR_DATA, v);
    chk(v, 32'(DATA_RST), "data reset");
    st(ST_NONE);
    wr(8'h10, 8'h55);
    chk(32'(resp_q), 32'(RESP_SLVERR), "write resp");
    rd(8'h10, v);
    chk(32'(resp_q), 32'(RESP_SLVERR), "read resp");
    // addressed for read, byte acked, last byte acked anyway
    wr(ADDR_OWN, {OWN_A, 1'b1});
    wr(ADDR_CTRL, 8'h44);
    M.start();
    M.wbyte({OWN_A, 1'b1}, a);
    chk(32'(a), 0, "addr ack");
    st(ST_OWN_ADDRESS_WITH_READ);
    send(8'ha5, 8'hc4);
    M.rbyte(1'b0, d);
    chk(32'(d), 32'ha5, "byte");
    st(ST_DAT_ACK);
    send(8'h3c, 8'h84);
    M.rbyte(1'b0, d);
    chk(32'(d), 32'h3c, "last byte");
    st(ST_LAST_AK);
    wr(ADDR_CTRL, 8'ha4);
    M.rbyte(1'b1, d);
    chk(32'(d), 32'hff, "ignored byte");
    // start request waits for the stop
    fork
      M.stop();
      begin
        n = 0;
        while (sda_oe_n !== 1'b0 && n < 300)
        begin
          @(posedge aclk);
          n++;
        end
      end
    join
    chk(32'(n < 300), 1, "start pulled");
    repeat (10) @(posedge aclk);
    rd(ADDR_CTRL, v);
    chk(v, 32'h04, "start cleared");
    M.start();
    M.wbyte({OWN_A, 1'b1}, a);
    chk(32'(a), 1, "ignored addr");
    M.stop();
    // lost arbitration, byte not acked, listening again
    wr(ADDR_CTRL, 8'h44);
    arb_lost <= 1'b1;
    M.start();
    M.wbyte({OWN_A, 1'b1}, a);
    st(ST_ARB_R);
    arb_lost <= 1'b0;
    send(8'h5a, 8'hc4);
    M.rbyte(1'b1, d);
    chk(32'(d), 32'h5a, "nacked byte");
    st(ST_DAT_NAK);
    wr(ADDR_CTRL, 8'hc4);
    M.stop();
    M.start();
    M.wbyte({OWN_A, 1'b1}, a);
    chk(32'(a), 0, "addr again");
    st(ST_OWN_ADDRESS_WITH_READ);
    // stop inside a data byte, then recovery
    send(8'hff, 8'hc4);
    M.bitx(1'b1, a);
    M.bitx(1'b1, a);
    M.stop();
    st(ST_BUSERR);
    chk(32'({scl_oe_n, sda_oe_n}), 32'h3, "lines released");
    chk(32'({scl_o, sda_o}), 0, "pin levels");
    wr(ADDR_CTRL, 8'hd4);
    rd(ADDR_CTRL, v);
    chk(v, 32'h44, "after recovery");
    st(ST_NONE);
    M.start();
    M.wbyte({OWN_A, 1'b1}, a);
    chk(32'(a), 0, "addr after recovery");
    summarize();
  end
endmodule
